// file: rts_pkg.sv
// Constants and types for the reset and start-up sequencer.
// Assumes a 200 MHz system clock; every time below is turned into a
// cycle count at that rate.
package rts_pkg;

    // Clock rate.
    localparam int CLK_MHZ = 200;

    // Power-on pulse stretch, a short settling delay after supply rise.
    localparam int POR_DELAY_NS = 50;
    localparam int POR_CYCLES   = (POR_DELAY_NS * CLK_MHZ + 999) / 1000;

    // Power-up timer, nominal 72 ms.
    localparam int POWER_UP_TIMER_TIME_MS = 72;
    localparam int POWER_UP_TIMER_CYCLES  = POWER_UP_TIMER_TIME_MS * CLK_MHZ * 1000;

    // Oscillator start-up count in oscillator input cycles.
    localparam int OST_EDGES = 1024;

    // Least low time on the brown-out comparator that counts as a dip.
    localparam int BOR_MIN_NS     = 100;
    localparam int BOR_MIN_CYCLES = (BOR_MIN_NS * CLK_MHZ + 999) / 1000;

    // Least low time on the reset pin that passes the noise filter.
    localparam int EXT_FILTER_NS     = 250;
    localparam int EXT_FILTER_CYCLES = (EXT_FILTER_NS * CLK_MHZ + 999) / 1000;

    // Length of the internal reset produced by a watchdog time-out.
    localparam int WDT_HOLD_NS     = 20;
    localparam int WDT_HOLD_CYCLES = (WDT_HOLD_NS * CLK_MHZ + 999) / 1000;

    // Counter widths.
    localparam int CNT_W  = 24;
    localparam int FILT_W = 9;

    // Register bus.
    localparam int ADDR_W = 8;
    localparam int DATA_W = 8;
    localparam logic [7:0] PWR_STATUS_OFFS = 8'h00;
    localparam logic [7:0] CAUSE_OFFS      = 8'h04;

    // Field positions.
    localparam int STAT_BOR_BIT   = 0;
    localparam int STAT_POR_BIT   = 1;
    localparam int CAUSE_TO_BIT   = 0;
    localparam int CAUSE_PD_BIT   = 1;
    localparam int CAUSE_ST_LSB   = 2;
    localparam int CAUSE_EXT_BIT  = 7;

    // Reset values.
    localparam logic [7:0] RDATA_RST = 8'h00;

    // Oscillator mode encoding.
    localparam logic [1:0] OSC_LP = 2'h0;
    localparam logic [1:0] OSC_XT = 2'h1;
    localparam logic [1:0] OSC_HS = 2'h2;
    localparam logic [1:0] OSC_RC = 2'h3;

    // Sequencer states.
    typedef enum logic [4:0] {
        RTS_ST_POR  = 5'h01,
        RTS_ST_POWER_UP_TIMER = 5'h02,
        RTS_ST_OST  = 5'h04,
        RTS_ST_BOR  = 5'h08,
        RTS_ST_RUN  = 5'h10
    } rts_state_type;

endpackage : rts_pkg

// file: rts_sequencer.sv
// Reset and start-up sequencer: power-on pulse, power-up timer,
// oscillator start-up count, brown-out reset, filtered reset pin,
// watchdog reset and the reset cause flags.
// Assumes the configuration inputs are static while the clock runs,
// and that rst_n_i is the supply-rise reset of this logic itself.
//
// Summary of operation
// RULE1: After power-on, hold reset while the 72 ms power-up timer runs.
// RULE2: Power-up timer enable bit low runs the timer; high skips it.
// RULE3: After the power-up timer, count 1024 oscillator cycles before release.
// RULE4: Start-up count only in crystal modes after power-on, brown-out, wake.
// RULE5: Brown-out reset works only while its enable bit is high.
// RULE6: Supply below threshold longer than the least pulse causes brown-out.
// RULE7: Stay in brown-out while low; on recovery run a further 72 ms.
// RULE8: A new dip during the power-up timer re-enters brown-out, restarts.
// RULE9: Software should keep the power-up timer on when brown-out is on.
// RULE10: Order on power-up: power-on delay, power-up timer, start-up count.
// RULE11: RC mode with power-up timer off has no time-out at all.
// RULE12: Time-outs ignore the reset pin; late pin release starts at once.
// RULE13: The reset pin passes a filter that discards short pulses.
// RULE14: A watchdog reset never drives the reset pin low.
// RULE15: Reset-state registers load on resets but not on watchdog wake.
// RULE16: Registers without reset state keep values through non-power resets.
// RULE17: Status bit 0 is the brown-out flag, cleared by brown-out reset.
// RULE18: With brown-out disabled the brown-out flag has no meaning.
// RULE19: Status bit 1 is the power-on flag, cleared only by power-on.
// RULE20: Expired and sleep flags together decode the cause of reset.
// RULE21: A supply-rise detection makes a power-on pulse starting the sequence.
// RULE22: Internal reset is the OR of all reset sources and running timers.
// RULE23: Start-up counter clears per invocation and counts oscillator edges.
//
// Our own choices: the address map and the plain strobed port.
`timescale 1ns/10ps

module rts_sequencer
    import rts_pkg::*;
#(
    parameter int POWER_UP_TIMER_CYCLES_P = POWER_UP_TIMER_CYCLES
) (
    // Clock and reset.
    input  wire logic              clk_i,
    input  wire logic              rst_n_i,
    // Pins from the board and the analog monitors.
    input  wire logic              external_reset_pin_n_i,
    output logic                   external_reset_pin_o,
    output logic                   external_reset_pin_oe_o,
    input  wire logic              supply_rise_i,
    input  wire logic              brownout_low_i,
    input  wire logic              oscillator_input_i,
    // Configuration bits.
    input  wire logic              power_up_timer_enable_i,
    input  wire logic              brownout_enable_bit_i,
    input  wire logic [1:0]        osc_mode_i,
    // Core events, on this clock.
    input  wire logic              watchdog_timeout_i,
    input  wire logic              sleep_enter_i,
    input  wire logic              interrupt_wake_i,
    // Reset outputs.
    output logic                   core_reset_o,
    output logic                   reg_reset_load_o,
    // Register port.
    input  wire logic [ADDR_W-1:0] addr_i,
    input  wire logic [DATA_W-1:0] wdata_i,
    input  wire logic              we_i,
    input  wire logic              re_i,
    output logic      [DATA_W-1:0] rdata_o
);

    localparam logic [CNT_W-1:0]  POR_LAST  = CNT_W'(POR_CYCLES - 1);
    localparam logic [CNT_W-1:0]  POWER_UP_TIMER_LAST = CNT_W'(POWER_UP_TIMER_CYCLES_P - 1);
    localparam logic [CNT_W-1:0]  OST_LAST  = CNT_W'(OST_EDGES - 1);
    localparam logic [FILT_W-1:0] BOR_MIN   = FILT_W'(BOR_MIN_CYCLES);
    localparam logic [FILT_W-1:0] EXT_MIN   = FILT_W'(EXT_FILTER_CYCLES);
    localparam logic [3:0]        WDT_HOLD  = 4'(WDT_HOLD_CYCLES);
    // The pin stage resets to its released level, so no false low follows.
    localparam logic [3:0]        SYNC_RST  = 4'h1;

    // Pin synchronisers: bit 0 reset pin, 1 brown-out, 2 supply, 3 osc.
    logic [3:0] pin_raw;
    logic [3:0] s1_reg;
    logic [3:0] s2_reg;
    logic [3:0] s3_reg;
    logic [3:0] stable_reg;
    logic [3:0] stable_next;

    assign pin_raw = {oscillator_input_i, supply_rise_i,
                      brownout_low_i, external_reset_pin_n_i};

    // A change is taken only once the second and third stages agree.
    genvar gi;
    generate
        for (gi = 0; gi < 4; gi++) begin : g_sync
            assign stable_next[gi] = (s2_reg[gi] == s3_reg[gi]) ?
                                     s3_reg[gi] : stable_reg[gi];
            always_ff @(posedge clk_i or negedge rst_n_i) begin
                if (!rst_n_i) begin
                    s1_reg[gi]     <= SYNC_RST[gi];
                    s2_reg[gi]     <= SYNC_RST[gi];
                    s3_reg[gi]     <= SYNC_RST[gi];
                    stable_reg[gi] <= SYNC_RST[gi];
                end else begin
                    s1_reg[gi]     <= pin_raw[gi];
                    s2_reg[gi]     <= s1_reg[gi];
                    s3_reg[gi]     <= s2_reg[gi];
                    stable_reg[gi] <= stable_next[gi];
                end
            end
        end
    endgenerate

    wire pin_low  = ~stable_reg[0];
    wire bor_low  = stable_reg[1];
    // RULE21 power-on pulse
    wire por_evt  = stable_next[2] & ~stable_reg[2];
    // RULE23 oscillator edge
    wire osc_rise = stable_next[3] & ~stable_reg[3];

    // Noise filters on the reset pin and the brown-out comparator.
    logic [FILT_W-1:0] ext_cnt_reg;
    logic [FILT_W-1:0] ext_cnt_next;
    logic [FILT_W-1:0] bor_cnt_reg;
    logic [FILT_W-1:0] bor_cnt_next;
    logic              ext_rst_reg;
    logic              ext_rst_next;

    // RULE13 pin filter
    assign ext_cnt_next = !pin_low ? '0 :
                          (ext_cnt_reg == EXT_MIN) ? ext_cnt_reg :
                          ext_cnt_reg + FILT_W'(1);
    assign ext_rst_next = pin_low & (ext_cnt_next == EXT_MIN);
    assign bor_cnt_next = !bor_low ? '0 :
                          (bor_cnt_reg == BOR_MIN) ? bor_cnt_reg :
                          bor_cnt_reg + FILT_W'(1);

    // RULE5 enable gate
    // RULE6 qualified dip
    wire bor_trip = brownout_enable_bit_i & (bor_cnt_reg == BOR_MIN);

    // Watchdog reset hold and sleep tracking.
    logic [3:0] wdt_cnt_reg;
    logic [3:0] wdt_cnt_next;
    logic       sleep_reg;
    logic       sleep_next;
    logic       wake_hold_reg;
    logic       wake_hold_next;

    wire wdt_reset  = watchdog_timeout_i & ~sleep_reg;
    wire wdt_wake   = watchdog_timeout_i & sleep_reg;
    wire wake_evt   = sleep_reg & (watchdog_timeout_i | interrupt_wake_i);
    wire wdt_active = (wdt_cnt_reg != 4'h0);
    wire ext_fall   = ext_rst_next & ~ext_rst_reg;
    wire crystal    = (osc_mode_i != OSC_RC);
    wire any_reset  = por_evt | bor_trip | ext_rst_next | wdt_reset;

    assign wdt_cnt_next = wdt_reset  ? WDT_HOLD :
                          wdt_active ? wdt_cnt_reg - 4'h1 : 4'h0;
    assign sleep_next   = any_reset | wake_evt ? 1'b0 :
                          sleep_enter_i ? 1'b1 : sleep_reg;
    // RULE15 wake keeps registers
    assign wake_hold_next = any_reset ? 1'b0 :
                            (wake_evt & crystal) ? 1'b1 : wake_hold_reg;

    // Sequencer.
    rts_state_type    state_reg;
    rts_state_type    state_next;
    logic [CNT_W-1:0] cnt_reg;
    logic [CNT_W-1:0] cnt_next;

    always_comb begin
        state_next = state_reg;
        cnt_next   = cnt_reg;
        case (state_reg)
            RTS_ST_POR: begin
                cnt_next = cnt_reg + CNT_W'(1);
                // RULE10 power-up order
                if (cnt_reg == POR_LAST) begin
                    cnt_next = '0;
                    // RULE2 timer bypass
                    if (!power_up_timer_enable_i) begin
                        state_next = RTS_ST_POWER_UP_TIMER;
                    end else if (crystal) begin
                        state_next = RTS_ST_OST;
                    end else begin
                        // RULE11 no time-out
                        state_next = RTS_ST_RUN;
                    end
                end
            end
            RTS_ST_POWER_UP_TIMER: begin
                cnt_next = cnt_reg + CNT_W'(1);
                // RULE3 start-up after timer
                if (cnt_reg == POWER_UP_TIMER_LAST) begin
                    cnt_next   = '0;
                    state_next = crystal ? RTS_ST_OST : RTS_ST_RUN;
                end
            end
            RTS_ST_OST: begin
                // RULE23 count edges
                if (osc_rise) begin
                    cnt_next = cnt_reg + CNT_W'(1);
                    if (cnt_reg == OST_LAST) begin
                        cnt_next   = '0;
                        state_next = RTS_ST_RUN;
                    end
                end
            end
            RTS_ST_BOR: begin
                cnt_next = '0;
                // RULE7 recovery delay
                if (!bor_low) begin
                    state_next = RTS_ST_POWER_UP_TIMER;
                end
            end
            RTS_ST_RUN: begin
                cnt_next = '0;
                // RULE4 wake start-up
                if (wake_evt && crystal) begin
                    state_next = RTS_ST_OST;
                end
            end
            default: begin
                cnt_next   = '0;
                state_next = RTS_ST_POR;
            end
        endcase
        // RULE8 dip restarts
        if (bor_trip) begin
            cnt_next   = '0;
            state_next = RTS_ST_BOR;
        end
        if (por_evt) begin
            cnt_next   = '0;
            state_next = RTS_ST_POR;
        end
    end

    // Reset cause flags; power-on and brown-out take priority over the core events.
    logic to_reg;
    logic to_next;
    logic pd_reg;
    logic pd_next;

    // RULE20 cause flags
    always_comb begin
        to_next = to_reg;
        pd_next = pd_reg;
        if (por_evt || (bor_trip && state_reg != RTS_ST_BOR)) begin
            to_next = 1'b1;
            pd_next = 1'b1;
        end else if (wdt_reset) begin
            to_next = 1'b0;
            pd_next = 1'b1;
        end else if (wdt_wake) begin
            to_next = 1'b0;
            pd_next = 1'b0;
        end else if (sleep_enter_i ||
                     ((interrupt_wake_i || ext_fall) && sleep_reg)) begin
            to_next = 1'b1;
            pd_next = 1'b0;
        end
    end

    // Status register: software sets the flags, hardware clears win.
    logic bor_flag_reg;
    logic bor_flag_next;
    logic por_flag_reg;
    logic por_flag_next;

    wire wr_status = we_i & (addr_i == PWR_STATUS_OFFS);

    // RULE17 brown-out flag
    // RULE18 flag unspecified when brown-out is off
    assign bor_flag_next = (bor_trip && state_reg != RTS_ST_BOR) ? 1'b0 :
                           wr_status ? wdata_i[STAT_BOR_BIT] : bor_flag_reg;
    // RULE19 power-on flag
    // RULE16 untouched by other resets
    assign por_flag_next = por_evt ? 1'b0 :
                           wr_status ? wdata_i[STAT_POR_BIT] : por_flag_reg;

    // Read decode, registered one cycle after the strobe.
    wire [DATA_W-1:0] status_word =
        {6'h00, por_flag_reg, bor_flag_reg};
    wire [DATA_W-1:0] cause_word =
        {ext_rst_reg, state_reg, pd_reg, to_reg};
    wire [DATA_W-1:0] rdata_next =
        !re_i                  ? RDATA_RST   :
        addr_i == PWR_STATUS_OFFS ? status_word :
        addr_i == CAUSE_OFFS   ? cause_word  : RDATA_RST;

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            ext_cnt_reg   <= '0;
            bor_cnt_reg   <= '0;
            ext_rst_reg   <= 1'b0;
            wdt_cnt_reg   <= 4'h0;
            sleep_reg     <= 1'b0;
            wake_hold_reg <= 1'b0;
            state_reg     <= RTS_ST_POR;
            cnt_reg       <= '0;
            to_reg        <= 1'b1;
            pd_reg        <= 1'b1;
            bor_flag_reg  <= 1'b0;
            por_flag_reg  <= 1'b0;
            rdata_o       <= RDATA_RST;
        end else begin
            ext_cnt_reg   <= ext_cnt_next;
            bor_cnt_reg   <= bor_cnt_next;
            ext_rst_reg   <= ext_rst_next;
            wdt_cnt_reg   <= wdt_cnt_next;
            sleep_reg     <= sleep_next;
            wake_hold_reg <= wake_hold_next;
            state_reg     <= state_next;
            cnt_reg       <= cnt_next;
            to_reg        <= to_next;
            pd_reg        <= pd_next;
            bor_flag_reg  <= bor_flag_next;
            por_flag_reg  <= por_flag_next;
            rdata_o       <= rdata_next;
        end
    end

    // The pin filter does not stop the timers, so a pin released late
    // only waits on the sequencer if the time-outs are still running.
    // RULE1 timer holds reset
    // RULE22 combined reset
    // RULE12 pin independent
    assign core_reset_o     = (state_reg != RTS_ST_RUN) | ext_rst_reg |
                              wdt_active;
    assign reg_reset_load_o = core_reset_o & ~wake_hold_reg;

    // RULE14 pin never driven
    assign external_reset_pin_o    = 1'b0;
    assign external_reset_pin_oe_o = 1'b0;

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rst_n_i);

    AST_POWER_UP_TIMER_HOLDS_RESET: assert property ( // RULE1
        state_reg == RTS_ST_POWER_UP_TIMER |-> core_reset_o && reg_reset_load_o)
        else $error("power-up timer running without reset");
    AST_POWER_UP_TIMER_BYPASS: assert property ( // RULE2
        state_reg == RTS_ST_POR && cnt_reg == POR_LAST &&
        !por_evt && !bor_trip |=>
        (state_reg == RTS_ST_POWER_UP_TIMER) == !$past(power_up_timer_enable_i))
        else $error("power-up timer enable bit not honoured");
    AST_OST_AFTER_POWER_UP_TIMER: assert property ( // RULE3
        state_reg == RTS_ST_POWER_UP_TIMER && cnt_reg == POWER_UP_TIMER_LAST && crystal &&
        !por_evt && !bor_trip |=> state_reg == RTS_ST_OST && cnt_reg == 0)
        else $error("start-up count did not follow power-up timer");
    AST_OST_CRYSTAL_ONLY: assert property ( // RULE4
        $rose(state_reg == RTS_ST_OST) |-> $past(crystal))
        else $error("start-up count entered in RC mode");
    AST_BOR_DISABLED: assert property ( // RULE5
        !brownout_enable_bit_i && state_reg != RTS_ST_BOR |=>
        state_reg != RTS_ST_BOR)
        else $error("brown-out reset while disabled");
    AST_BOR_ENTRY: assert property ( // RULE6
        bor_trip && !por_evt |=> state_reg == RTS_ST_BOR ##1
        (state_reg == RTS_ST_BOR || state_reg == RTS_ST_POWER_UP_TIMER ||
         state_reg == RTS_ST_POR))
        else $error("qualified dip did not enter brown-out reset");
    AST_BOR_RECOVERY: assert property ( // RULE7
        state_reg == RTS_ST_BOR && !bor_low && !bor_trip && !por_evt |=>
        state_reg == RTS_ST_POWER_UP_TIMER && cnt_reg == 0)
        else $error("brown-out recovery did not restart the timer");
    AST_BOR_RESTART: assert property ( // RULE8
        state_reg == RTS_ST_POWER_UP_TIMER && bor_trip && !por_evt |=>
        state_reg == RTS_ST_BOR && cnt_reg == 0)
        else $error("dip during power-up timer not handled");
    AST_ORDER: assert property ( // RULE10
        $rose(state_reg == RTS_ST_POWER_UP_TIMER) |->
        $past(state_reg) == RTS_ST_POR || $past(state_reg) == RTS_ST_BOR)
        else $error("power-up timer entered out of order");
    AST_RC_NO_TIMEOUT: assert property ( // RULE11
        state_reg == RTS_ST_POR && cnt_reg == POR_LAST &&
        power_up_timer_enable_i && !crystal && !por_evt && !bor_trip |=>
        state_reg == RTS_ST_RUN)
        else $error("time-out applied in RC mode without timer");
    AST_PIN_FILTER: assert property ( // RULE13
        $rose(ext_rst_reg) |-> $past(ext_cnt_reg) == EXT_MIN - FILT_W'(1))
        else $error("reset pin passed the filter too early");
    AST_WAKE_KEEPS_REGS: assert property ( // RULE15
        wdt_wake && crystal && !any_reset |=>
        state_reg == RTS_ST_OST && !reg_reset_load_o)
        else $error("watchdog wake loaded register reset state");
    AST_POR_FLAG: assert property ( // RULE19
        por_evt |=> !por_flag_reg && to_reg && pd_reg)
        else $error("power-on did not clear the power-on flag");
    AST_BOR_FLAG: assert property ( // RULE17
        bor_trip && state_reg != RTS_ST_BOR |=> !bor_flag_reg)
        else $error("brown-out reset did not clear its flag");
    AST_WDT_CAUSE: assert property ( // RULE20
        wdt_reset && !por_evt && !bor_trip |=>
        !to_reg && pd_reg && core_reset_o [*3])
        else $error("watchdog reset cause flags wrong");

endmodule : rts_sequencer

// file: rts_board_model.sv
// Board model: reset pin with pull-up and an external crystal.
// Assumes the bench steers it through level commands.
`timescale 1ns/10ps

module rts_board_model (
    // Commands from the bench.
    input  wire logic pin_low_i,
    input  wire logic osc_run_i,
    // Pin drive from the device.
    input  wire logic pin_drv_i,
    input  wire logic pin_oe_i,
    // Lines into the device.
    output logic      pin_n_o,
    output logic      osc_o
);
    // The pull-up wins unless some party pulls the line low.
    assign pin_n_o = !(pin_low_i || (pin_oe_i && !pin_drv_i));

    // A stopped crystal stands low, so a wrong wait for it would hang.
    initial begin
        osc_o = 1'b0;
        forever begin
            #20;
            osc_o = osc_run_i ? !osc_o : 1'b0;
        end
    end
endmodule : rts_board_model

// file: testbench.sv
// Self-checking bench for the reset and start-up sequencer.
// Assumes a 200 MHz clock and a shortened power-up timer of 50 cycles.
`timescale 1ns/10ps

module testbench;
    import rts_pkg::*;
    logic       clk, rst_n, pin_low, osc_run, rise, brown, pte, boe, we, re;
    logic [1:0] mode;
    logic [2:0] ev, h;
    logic [7:0] addr, wdata, d;
    wire logic  pin_n, osc, pin_drv, pin_oe, core, load;
    wire logic [7:0] rdata;
    int         error_cnt, num_checks, n;

    rts_board_model board_u (.pin_low_i(pin_low), .osc_run_i(osc_run),
        .pin_drv_i(pin_drv), .pin_oe_i(pin_oe), .pin_n_o(pin_n), .osc_o(osc));

    rts_sequencer #(.POWER_UP_TIMER_CYCLES_P(50)) dut_u (.clk_i(clk), .rst_n_i(rst_n),
        .external_reset_pin_n_i(pin_n), .external_reset_pin_o(pin_drv),
        .external_reset_pin_oe_o(pin_oe), .supply_rise_i(rise),
        .brownout_low_i(brown), .oscillator_input_i(osc),
        .power_up_timer_enable_i(pte), .brownout_enable_bit_i(boe),
        .osc_mode_i(mode), .watchdog_timeout_i(ev[0]),
        .sleep_enter_i(ev[1]), .interrupt_wake_i(ev[2]),
        .core_reset_o(core), .reg_reset_load_o(load), .addr_i(addr),
        .wdata_i(wdata), .we_i(we), .re_i(re), .rdata_o(rdata));

    initial begin
        clk = 1'b0;
        forever #2.5 clk = !clk;
    end

    task print_verdict;
        $display("checks %0d errors %0d", num_checks, error_cnt);
        if (error_cnt == 0 && num_checks > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask : print_verdict

    task check(input string nm, input logic [7:0] seen, input logic [7:0] ex);
        num_checks++;
        if (seen !== ex) begin
            error_cnt++;
            $display("[FAIL] %s expected %h seen %h", nm, ex, seen);
        end
    endtask : check

    task wr(input logic [7:0] a, input logic [7:0] v);
        @(posedge clk) {addr, wdata, we} <= {a, v, 1'b1};
        @(posedge clk) we <= 1'b0;
    endtask : wr

    task rd(input logic [7:0] a);
        @(posedge clk) {addr, re} <= {a, 1'b1};
        @(posedge clk) re <= 1'b0;
        #1 d = rdata;
    endtask : rd

    task evt(input logic [2:0] e);
        @(posedge clk) ev <= e;
        @(posedge clk) ev <= 3'h0;
    endtask : evt

    // Collects {pin enable, register load, core reset} seen over a window.
    task watch(input int c);
        h = 3'h0;
        repeat (c) begin
            @(posedge clk) #1 h = h | {pin_oe, load, core};
        end
    endtask : watch

    task wait_rel;
        n = 0;
        while (core !== 1'b0) begin
            @(posedge clk) #1 n++;
            if (n > 20000) begin
                error_cnt++;
                print_verdict();
            end
        end
    endtask : wait_rel

    // Configuration only changes while the sequencer is held in reset.
    task por(input logic [1:0] m, input logic p, input logic b);
        @(posedge clk) {rst_n, mode, pte, boe} <= {1'b0, m, p, b};
        osc_run <= (m != OSC_RC);
        repeat (12) @(posedge clk);
        rst_n <= 1'b1;
        wait_rel();
    endtask : por

    logic [1:0] md [4] = '{OSC_RC, OSC_RC, OSC_HS, OSC_LP};
    logic       pt [4] = '{1'b1, 1'b0, 1'b0, 1'b1};
    int         lo [4] = '{10, 59, 8244, 8194};
    int         hi [4] = '{13, 64, 8272, 8222};

    initial begin
        {rst_n, pin_low, osc_run, rise, brown, pte, boe, we, re} = 9'h0;
        {mode, ev, addr, wdata} = 21'h0;
        error_cnt = 0;
        num_checks = 0;
        for (int i = 0; i < 4; i++) begin
            por(md[i], pt[i], 1'b0);
            check("release", 8'(n >= lo[i] && n <= hi[i]), 8'h01);
        end
        rd(8'h00); check("status", d, 8'h00);
        wr(8'h00, 8'h03); rd(8'h00); check("status", d, 8'h03);
        wr(8'h04, 8'hFF); rd(8'h04); check("flags", {6'h0, d[1:0]}, 8'h03);
        rd(8'h10); check("unmapped", d, 8'h00);
        @(posedge clk) pin_low <= 1'b1;
        repeat (20) @(posedge clk);
        pin_low <= 1'b0;
        watch(40); check("short pin", {5'h0, h}, 8'h00);
        pin_low <= 1'b1;
        watch(80); check("long pin", {5'h0, h}, 8'h03);
        pin_low <= 1'b0;
        wait_rel();
        rd(8'h00); check("status", d, 8'h03);
        evt(3'h1); watch(10); check("wdt", {5'h0, h}, 8'h03);
        rd(8'h04); check("flags", {6'h0, d[1:0]}, 8'h02);
        evt(3'h2); rd(8'h04); check("flags", {6'h0, d[1:0]}, 8'h01);
        evt(3'h1); watch(20); check("wake", {5'h0, h}, 8'h01);
        wait_rel(); check("ost", 8'(n > 8000), 8'h01);
        rd(8'h04); check("flags", {6'h0, d[1:0]}, 8'h00);
        evt(3'h2); evt(3'h4); rd(8'h04); check("flags", {6'h0, d[1:0]}, 8'h01);
        wait_rel();
        por(OSC_XT, 1'b0, 1'b1);
        wr(8'h00, 8'h03);
        @(posedge clk) brown <= 1'b1;
        repeat (10) @(posedge clk);
        brown <= 1'b0;
        watch(30); check("short dip", {5'h0, h}, 8'h00);
        brown <= 1'b1;
        watch(40); check("dip", {5'h0, h}, 8'h03);
        rd(8'h04); check("state", {3'h0, d[6:2]}, 8'h08);
        rd(8'h00); check("status", d, 8'h02);
        brown <= 1'b0;
        repeat (20) @(posedge clk);
        rd(8'h04); check("state", {3'h0, d[6:2]}, 8'h02);
        brown <= 1'b1;
        repeat (40) @(posedge clk);
        rd(8'h04); check("state", {3'h0, d[6:2]}, 8'h08);
        brown <= 1'b0;
        repeat (45) @(posedge clk);
        rd(8'h04); check("state", {3'h0, d[6:2]}, 8'h02);
        repeat (20) @(posedge clk);
        rd(8'h04); check("state", {3'h0, d[6:2]}, 8'h04);
        wait_rel();
        por(OSC_XT, 1'b0, 1'b0);
        brown <= 1'b1;
        watch(40); check("bor off", {5'h0, h}, 8'h00);
        brown <= 1'b0;
        pin_low <= 1'b1;
        fork
            por(OSC_RC, 1'b0, 1'b0);
            begin
                repeat (100) @(posedge clk);
                #1 check("pin held", {7'h0, core}, 8'h01);
                pin_low <= 1'b0;
            end
        join
        check("late pin", 8'(n >= 88 && n <= 96), 8'h01);
        wr(8'h00, 8'h03);
        @(posedge clk) rise <= 1'b1;
        watch(8); check("rise", {5'h0, h}, 8'h03);
        rise <= 1'b0;
        rd(8'h00); check("status", {6'h0, d[1:0]}, 8'h01);
        print_verdict();
    end
endmodule : testbench
